// ### scpc_top.sv
// system clock prescaler control: registers, unlock, trim and clock output
`timescale 1ns/1ps
`default_nettype none
module scpc_top #(
  parameter int         D4_CYC       = scpc_pkg::DELAY_4_CYC,
  parameter int         D64_CYC      = scpc_pkg::DELAY_64_CYC,
  parameter logic [7:0] FACTORY_TRIM = 8'h80 // arbitrary default trim
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  input  wire logic [3:0] source_select_fuses,
  input  wire logic [1:0] startup_delay_fuses,
  input  wire logic       divide_by_eight_fuse,
  input  wire logic       clock_output_fuse,
  output logic            clk_io_en,
  output logic            clk_adc_en,
  output logic            clk_cpu_en,
  output logic            clk_flash_en,
  output logic            clock_output_pin,
  output logic            clock_output_oe_n,
  output logic [7:0]      trim_value,
  output logic            startup_done
);
  logic [3:0] division_select_r;
  logic       prescale_change_enable_r;
  logic [2:0] pce_cnt_r;
  logic [2:0] fuse_sync_r;
  logic [1:0] fill_r;
  logic       strap_done_r;
  logic       tick;
  logic       ready;
  logic       wr_pre;
  logic       wr_trim;
  logic       clk_out_r;

  assign wr_pre  = wr && (addr == scpc_pkg::ADDR_PRESCALE);
  assign wr_trim = wr && (addr == scpc_pkg::ADDR_TRIM);

  // fuse level passes three flops; two last agree before use
  // fill_r marks the chain as holding real pin samples, not reset zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuse_sync_r <= 3'b000;
      fill_r      <= 2'h0;
    end else begin
      fuse_sync_r <= {fuse_sync_r[1:0], divide_by_eight_fuse};
      if (fill_r != 2'h3) fill_r <= 2'(fill_r + 2'h1);
    end
  end

  // unlock window: set on a clean write, count four cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_change_enable_r <= 1'b0;
      pce_cnt_r                <= 3'h0;
    end else if (prescale_change_enable_r) begin
      if (wr_pre && !wdata[scpc_pkg::PCE_BIT]) begin
        prescale_change_enable_r <= 1'b0;
      end else if (pce_cnt_r == scpc_pkg::PCE_WINDOW - 3'h1) begin
        prescale_change_enable_r <= 1'b0;
      end else begin
        pce_cnt_r <= 3'(pce_cnt_r + 3'h1);
      end
    end else if (wr_pre && wdata == 8'h80) begin
      prescale_change_enable_r <= 1'b1;
      pce_cnt_r                <= 3'h0;
    end
  end

  // select bits: strap after reset release, then unlocked writes only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      division_select_r <= scpc_pkg::DIV_RESET_DIV8;
      strap_done_r      <= 1'b0;
    end else if (!strap_done_r) begin
      if (fill_r == 2'h3 && fuse_sync_r[2] == fuse_sync_r[1]) begin
        strap_done_r      <= 1'b1;
        division_select_r <= fuse_sync_r[2] ? scpc_pkg::DIV_RESET_DIV8
                                            : scpc_pkg::DIV_RESET_DIV1;
      end
    end else if (wr_pre && prescale_change_enable_r && !wdata[scpc_pkg::PCE_BIT]) begin
      division_select_r <= wdata[3:0];
    end
  end

  // trim register loaded at reset, later written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst)          trim_value <= FACTORY_TRIM;
    else if (wr_trim) trim_value <= wdata;
  end

  // read data one cycle after strobe; reserved bits zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        scpc_pkg::ADDR_PRESCALE: rdata <= {prescale_change_enable_r, 3'b000, division_select_r};
        scpc_pkg::ADDR_TRIM:     rdata <= trim_value;
        default:                 rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  scpc_divider u_div (
    .clk        (clk),
    .rst        (rst),
    .div_sel    (division_select_r),
    .sys_tick   (tick),
    .div_active ()
  );

  scpc_startup #(.D4(D4_CYC), .D64(D64_CYC)) u_start (
    .clk                 (clk),
    .rst                 (rst),
    .source_select_fuses (source_select_fuses),
    .startup_delay_fuses (startup_delay_fuses),
    .ready               (ready)
  );

  // all four domains share one divided enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_io_en    <= 1'b0;
      clk_adc_en   <= 1'b0;
      clk_cpu_en   <= 1'b0;
      clk_flash_en <= 1'b0;
      startup_done <= 1'b0;
    end else begin
      clk_io_en    <= tick && ready;
      clk_adc_en   <= tick && ready;
      clk_cpu_en   <= tick && ready;
      clk_flash_en <= tick && ready;
      startup_done <= ready;
    end
  end

  // divided clock toggles per tick, driven on the pin when fused
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_out_r         <= 1'b0;
      clock_output_pin  <= 1'b0;
      clock_output_oe_n <= 1'b1;
    end else begin
      if (tick) clk_out_r <= ~clk_out_r;
      clock_output_pin  <= clk_out_r && clock_output_fuse && ready;
      clock_output_oe_n <= ~clock_output_fuse;
    end
  end
endmodule : scpc_top
`default_nettype wire

// ### scpc_pkg.sv
// constants and types shared by the system clock prescaler control block
package scpc_pkg;
  localparam logic [7:0] ADDR_PRESCALE    = 8'h28;
  localparam logic [7:0] ADDR_TRIM        = 8'h29;
  localparam int         PCE_BIT          = 7;
  localparam logic [3:0] DIV_RESET_DIV8   = 4'h3;
  localparam logic [3:0] DIV_RESET_DIV1   = 4'h0;
  localparam logic [3:0] DIV_MAX          = 4'h8;
  localparam logic [2:0] PCE_WINDOW       = 3'h4;
  localparam logic [3:0] SHIP_SOURCE      = 4'h2;
  localparam logic [1:0] SHIP_STARTUP     = 2'h2;
  localparam int         CLK_MHZ          = 200;
  localparam int         SHORT_CK         = 14;
  localparam int         XTAL_CK          = 16384;
  localparam int         RESO_CK          = 1024;
  localparam int         DELAY_4_MS       = 4;
  localparam int         DELAY_64_MS      = 64;
  localparam int         DELAY_4_CYC      = DELAY_4_MS * CLK_MHZ * 1000;
  localparam int         DELAY_64_CYC     = DELAY_64_MS * CLK_MHZ * 1000;
  typedef enum logic [1:0] {
    SCPC_ST_WAIT  = 2'b00,
    SCPC_ST_DELAY = 2'b01,
    SCPC_ST_RUN   = 2'b10
  } scpc_state_type;
endpackage : scpc_pkg

// ### scpc_divider.sv
// synchronous-counter power-of-two divider with glitch-free rate switching
`timescale 1ns/1ps
`default_nettype none
module scpc_divider (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] div_sel,
  output logic            sys_tick,
  output logic [3:0]      div_active
);
  logic [7:0] cnt_r;
  logic [3:0] act_r;
  logic [3:0] pend_r;
  logic       tick_r;
  logic [7:0] mask;

  // reserved codes clamp to divide by 256
  always_comb begin
    logic [3:0] eff;
    eff  = (div_sel > scpc_pkg::DIV_MAX) ? scpc_pkg::DIV_MAX : div_sel;
    mask = 8'((9'h001 << act_r) - 9'h001);
    pend_r = eff;
  end

  // count source cycles; a tick ends each divided period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 8'h00;
      act_r  <= 4'h0;
      tick_r <= 1'b0;
    end else if ((cnt_r & mask) == mask) begin
      cnt_r  <= 8'h00;
      tick_r <= 1'b1;
      act_r  <= pend_r; // switch only at a period boundary
    end else begin
      cnt_r  <= 8'(cnt_r + 8'h01);
      tick_r <= 1'b0;
    end
  end

  assign sys_tick   = tick_r;
  assign div_active = act_r;
endmodule : scpc_divider
`default_nettype wire

// ### scpc_startup.sv
// start-up delay counter chosen by the source and start-up fuses
`timescale 1ns/1ps
`default_nettype none
module scpc_startup #(
  parameter int D4  = scpc_pkg::DELAY_4_CYC,
  parameter int D64 = scpc_pkg::DELAY_64_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] source_select_fuses,
  input  wire logic [1:0] startup_delay_fuses,
  output logic            ready
);
  scpc_pkg::scpc_state_type st_r;
  logic [31:0] cnt_r;
  logic [31:0] osc_len;
  logic [31:0] extra_len;

  // crystal and resonator lengths; other sources keep the short form
  always_comb begin
    osc_len   = 32'd0;
    extra_len = 32'(scpc_pkg::SHORT_CK);
    if (source_select_fuses[3]) begin
      case ({source_select_fuses[0], startup_delay_fuses})
        3'b011: begin osc_len = 32'(scpc_pkg::RESO_CK); extra_len = 32'(scpc_pkg::SHORT_CK + D4); end
        3'b100: begin osc_len = 32'(scpc_pkg::RESO_CK); extra_len = 32'(scpc_pkg::SHORT_CK + D64); end
        3'b101: begin osc_len = 32'(scpc_pkg::XTAL_CK); extra_len = 32'(scpc_pkg::SHORT_CK); end
        3'b110: begin osc_len = 32'(scpc_pkg::XTAL_CK); extra_len = 32'(scpc_pkg::SHORT_CK + D4); end
        3'b111: begin osc_len = 32'(scpc_pkg::XTAL_CK); extra_len = 32'(scpc_pkg::SHORT_CK + D64); end
        default: begin osc_len = 32'd0; extra_len = 32'(scpc_pkg::SHORT_CK); end
      endcase
    end
  end

  // oscillator settle, then reset delay, then run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r  <= scpc_pkg::SCPC_ST_WAIT;
      cnt_r <= 32'd0;
      ready <= 1'b0;
    end else begin
      case (st_r)
        scpc_pkg::SCPC_ST_WAIT: begin
          if (cnt_r >= osc_len) begin
            st_r  <= scpc_pkg::SCPC_ST_DELAY;
            cnt_r <= 32'd0;
          end else begin
            cnt_r <= cnt_r + 32'd1;
          end
        end
        scpc_pkg::SCPC_ST_DELAY: begin
          if (cnt_r >= extra_len) begin
            st_r  <= scpc_pkg::SCPC_ST_RUN;
            ready <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 32'd1;
          end
        end
        scpc_pkg::SCPC_ST_RUN: ready <= 1'b1;
        default: st_r <= scpc_pkg::SCPC_ST_WAIT;
      endcase
    end
  end
endmodule : scpc_startup
`default_nettype wire

// ### scpc_chk.sv
// concurrent checks on the prescaler control top ports
`timescale 1ns/1ps
`default_nettype none
module scpc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       clk_io_en,
  input wire logic       clk_adc_en,
  input wire logic       clk_cpu_en,
  input wire logic       clk_flash_en,
  input wire logic       clock_output_pin,
  input wire logic       clock_output_oe_n,
  input wire logic       clock_output_fuse,
  input wire logic [7:0] trim_value,
  input wire logic       startup_done
);
  default clocking cb @(posedge clk); endclocking
  // register port and domain relations
  a_rsvd_zero: assert property (disable iff (rst)
    rd && addr == scpc_pkg::ADDR_PRESCALE |=> rdata[6:4] == 3'h0) else $error("reserved bits set");
  a_domains_together: assert property (disable iff (rst) clk_cpu_en == clk_io_en
    && clk_cpu_en == clk_adc_en && clk_cpu_en == clk_flash_en) else $error("domains apart");
  a_no_early_tick: assert property (disable iff (rst)
    !startup_done |-> !clk_cpu_en && !clock_output_pin) else $error("tick before start");
  a_pin_quiet_rst: assert property (rst |-> !clock_output_pin) else $error("pin runs in reset");
  a_pin_enable: assert property (disable iff (rst)
    clock_output_fuse && $past(clock_output_fuse) && !$past(rst) |-> !clock_output_oe_n)
    else $error("pin not driven");
  a_trim_load: assert property (disable iff (rst)
    wr && addr == scpc_pkg::ADDR_TRIM |=> trim_value == $past(wdata)) else $error("trim not loaded");
  a_trim_hold: assert property (disable iff (rst)
    !(wr && addr == scpc_pkg::ADDR_TRIM) |=> $stable(trim_value)) else $error("trim moved");
  a_trim_read: assert property (disable iff (rst)
    rd && addr == scpc_pkg::ADDR_TRIM |=> rdata == $past(trim_value)) else $error("trim read");
  a_started_stays: assert property (disable iff (rst)
    startup_done |=> startup_done) else $error("start-up flag dropped");
endmodule : scpc_chk
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the prescaler control top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, rst, wr, rd, div8_fuse, out_fuse;
  logic [7:0] addr, wdata, rdata, trim_value;
  logic       io_en, adc_en, cpu_en, flash_en, pin, oe_n, done;
  logic [3:0] src_fuse;
  logic [1:0] sut_fuse;
  int         bad_count, samples_checked, g, pd, ex;
  scpc_top #(.D4_CYC(10), .D64_CYC(20)) dut_u (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .source_select_fuses(src_fuse),
    .startup_delay_fuses(sut_fuse), .divide_by_eight_fuse(div8_fuse),
    .clock_output_fuse(out_fuse), .clk_io_en(io_en), .clk_adc_en(adc_en),
    .clk_cpu_en(cpu_en), .clk_flash_en(flash_en), .clock_output_pin(pin),
    .clock_output_oe_n(oe_n), .trim_value(trim_value), .startup_done(done));
  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare one value and count it
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // one bus cycle: strobes sampled at the next edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : acc
  task automatic rdc(input logic [7:0] a, output logic [7:0] v);
    acc(1'b0, 1'b1, a, 8'h00);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    #1 v = rdata;
  endtask : rdc
  // cycles between two cpu ticks
  task automatic gap(output int n);
    n = 0;
    do @(negedge clk); while (cpu_en !== 1'b1 && ++n < 600);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_en !== 1'b1 && n < 600);
  endtask : gap
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // watchdog against a hung handshake; tests need about 36k cycles
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  logic [7:0] v;
  initial begin
    rst       = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    div8_fuse = 1'b1;
    out_fuse  = 1'b1;
    src_fuse  = 4'h2;
    sut_fuse  = 2'h2;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (24) @(posedge clk);
    rdc(8'h28, v); chk("prescale reset", v, 9'h003);
    rdc(8'h29, v); chk("trim reset", v, 9'h080);
    chk("started", done, 9'h001);
    acc(1'b1, 1'b0, 8'h28, 8'h80);
    rdc(8'h28, v); chk("enable set", v, 9'h083);
    repeat (6) acc(1'b0, 1'b0, 8'h00, 8'h00);
    rdc(8'h28, v); chk("enable timeout", v, 9'h003);
    acc(1'b1, 1'b0, 8'h28, 8'h05);
    rdc(8'h28, v); chk("locked select", v, 9'h003);
    acc(1'b1, 1'b0, 8'h28, 8'h81);
    acc(1'b1, 1'b0, 8'h28, 8'h05);
    rdc(8'h28, v); chk("impure enable", v, 9'h003);
    acc(1'b1, 1'b0, 8'h28, 8'h80);
    acc(1'b1, 1'b0, 8'h28, 8'h80);
    acc(1'b1, 1'b0, 8'h28, 8'h07);
    rdc(8'h28, v); chk("rewrite keeps", v, 9'h007);
    acc(1'b1, 1'b0, 8'h28, 8'h80);
    repeat (2) acc(1'b0, 1'b0, 8'h00, 8'h00);
    acc(1'b1, 1'b0, 8'h28, 8'h80);
    repeat (2) acc(1'b0, 1'b0, 8'h00, 8'h00);
    acc(1'b1, 1'b0, 8'h28, 8'h02);
    rdc(8'h28, v); chk("no restart", v, 9'h007);
    acc(1'b1, 1'b0, 8'h30, 8'hff);
    acc(1'b1, 1'b0, 8'h29, 8'h3c);
    rdc(8'h29, v); chk("trim write", v, 9'h03c);
    chk("trim port", trim_value, 9'h03c);
    rdc(8'h28, v); chk("unmapped write", v, 9'h007);
    $display("unlock tests done");
    pd = 128;
    // every select code: glitch floor during switch, then settled period
    for (int n = 0; n < 16; n++) begin
      ex = (n <= 8) ? (1 << n) : 256;
      acc(1'b1, 1'b0, 8'h28, 8'h80);
      acc(1'b1, 1'b0, 8'h28, 8'(n));
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      if (n <= 8) begin
        rdc(8'h28, v); chk("select code", v, 9'(n));
      end
      repeat (3) begin
        gap(g); chk("switch floor", 9'(g >= (pd < ex ? pd : ex)), 9'h001);
      end
      gap(g); chk("divided period", 9'(g), 9'(ex));
      pd = ex;
    end
    $display("divider tests done");
    // select is reserved now, so the pin must flip once per 256 cycles
    @(posedge clk);
    #1 v[0] = pin;
    repeat (256) @(posedge clk);
    #1 chk("pin toggles", pin, {8'h00, ~v[0]});
    chk("pin driven", oe_n, 9'h000);
    @(posedge clk);
    out_fuse <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("pin released", oe_n, 9'h001);
    chk("pin silent", pin, 9'h000);
    // second reset with a crystal code: long oscillator settle
    @(posedge clk);
    rst <= 1'b1;
    div8_fuse <= 1'b0;
    src_fuse <= 4'hf;
    sut_fuse <= 2'h1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(8'h28, v); chk("undivided reset", v, 9'h000);
    // 16384 settle plus 14 delay cycles must pass before start-up ends
    repeat (16386) @(posedge clk);
    #1 chk("xtal start early", done, 9'h000);
    repeat (8) @(posedge clk);
    #1 chk("xtal start done", done, 9'h001);
    $display("fuse tests done");
    tally_and_finish();
  end
endmodule : tb_top
bind scpc_top scpc_chk chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .clk_io_en(clk_io_en), .clk_adc_en(clk_adc_en),
  .clk_cpu_en(clk_cpu_en), .clk_flash_en(clk_flash_en), .clock_output_pin(clock_output_pin),
  .clock_output_oe_n(clock_output_oe_n), .clock_output_fuse(clock_output_fuse),
  .trim_value(trim_value), .startup_done(startup_done));
`default_nettype wire
